/* File: pnwk_can_node.sv */
// Behavioural CAN bus node feeding decoded bus events to the wake status block.
// Assumes it shares clk with the block and is steered by testbench task calls.
`timescale 1ns/100ps
`default_nettype none

module pnwk_can_node
    import pnwk_pkg::*;
(
    output var  logic                  frame_ok,
    output var  logic                  frame_err,
    output var  logic                  silence_exceeded,
    output var  logic                  wake_pattern_det,
    output var  logic                  wake_frame_det,
    output var  logic                  avg_valid,
    output var  logic [PNWK_AVG_W-1:0] averaged_bit_period,
    input  wire logic                  clk
);
    ////////////////////////////////////////////////////////////////////////////////
    // Quiet bus at start: no events, silence timer not expired
    initial begin
        {frame_ok, frame_err, wake_pattern_det, wake_frame_det} = 4'h0;
        silence_exceeded    = 1'b0;
        avg_valid           = 1'b0;
        averaged_bit_period = 12'h000;
    end

    // One event kind high for n back-to-back edges: 0 ok, 1 error, 2 pattern, 3 wake frame
    task automatic burst(input int sel, input int n);
        @(posedge clk);
        {frame_ok, frame_err, wake_pattern_det, wake_frame_det} <= 4'h8 >> sel;
        repeat (n) @(posedge clk);
        {frame_ok, frame_err, wake_pattern_det, wake_frame_det} <= 4'h0;
    endtask

    // Silence timer output is a level
    task automatic quiet(input logic on);
        @(posedge clk);
        silence_exceeded <= on;
    endtask

    // Period is only qualified for one cycle; afterwards show garbage, not a stale match
    task automatic period(input logic [PNWK_AVG_W-1:0] v);
        @(posedge clk);
        avg_valid           <= 1'b1;
        averaged_bit_period <= v;
        @(posedge clk);
        avg_valid           <= 1'b0;
        averaged_bit_period <= ~v;
    endtask
endmodule // pnwk_can_node

`default_nettype wire

/* File: pnwk_err_counter.sv */
// Saturating frame error counter for the partial-network wake channel.
// Assumes event inputs are single-cycle pulses on clk.
`timescale 1ns/100ps
`default_nettype none

module pnwk_err_counter
    import pnwk_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  count_up,
    input  wire logic                  count_down,
    output var  logic [PNWK_CNT_W-1:0] bad_frame_count,
    output var  logic                  overflow
);

    logic [PNWK_CNT_W-1:0] cnt_r;
    logic [PNWK_CNT_W-1:0] cnt_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next count; overflow freezes the value so software can see it
    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_r == PNWK_CNT_OVF) begin
            cnt_nxt = cnt_r;
        end else if (count_up) begin
            cnt_nxt = cnt_r + 6'h01; // R14
        end else if (count_down && cnt_r != PNWK_CNT_ZERO) begin
            cnt_nxt = cnt_r - 6'h01; // R9
        end
    end

    // Counter register, cleared to zero on reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= PNWK_CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt; // R8
        end
    end

    assign bad_frame_count = cnt_r;
    assign overflow        = (cnt_r == PNWK_CNT_OVF); // R10

    ////////////////////////////////////////////////////////////////////////
    // Checks on the counter
    AST_CNT_DECREMENT: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (count_down && !count_up && cnt_r != PNWK_CNT_ZERO && cnt_r != PNWK_CNT_OVF)
            |=> cnt_r == $past(cnt_r) - 6'h01)
        else $error("error count did not decrement on valid frame");

    AST_CNT_ZERO_STAYS: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (cnt_r == PNWK_CNT_ZERO && !count_up) |=> cnt_r == PNWK_CNT_ZERO)
        else $error("error count left zero without an error");

    AST_CNT_INCREMENT: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (count_up && cnt_r != PNWK_CNT_OVF) |=> cnt_r == $past(cnt_r) + 6'h01)
        else $error("error count did not increment on bad frame");

    AST_CNT_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // R8
        cnt_r <= PNWK_CNT_OVF)
        else $error("error count passed overflow value");

endmodule // pnwk_err_counter

`default_nettype wire

/* File: pnwk_pkg.sv */
// Shared constants for the channel 2 partial-network wake status block.
// Assumes a single 250 MHz clock and a synchronous, active-low reset.
`default_nettype none

package pnwk_pkg;

    // Register addresses on the 7-bit serial register port
    localparam logic [6:0] PNWK_ADDR_WAKE_STATUS = 7'h68;
    localparam logic [6:0] PNWK_ADDR_ERR_COUNT   = 7'h69;
    localparam logic [6:0] PNWK_ADDR_PERIOD_INT  = 7'h6A;
    localparam logic [6:0] PNWK_ADDR_PERIOD_FRAC = 7'h6B;

    // Field positions in the wake status register
    localparam int PNWK_BIT_SYNC   = 6;
    localparam int PNWK_BIT_QUIET  = 3;
    localparam int PNWK_BIT_ACTIVE = 2;
    localparam int PNWK_BIT_WUP    = 1;
    localparam int PNWK_BIT_WUF    = 0;

    // Frame error counter
    localparam int         PNWK_CNT_W    = 6;
    localparam logic [5:0] PNWK_CNT_ZERO = 6'h00;
    localparam logic [5:0] PNWK_CNT_OVF  = 6'h20;

    // Channel mode value that never arms partial-network wake, and the mode bit that gates the active flag
    localparam logic [2:0] PNWK_MODE_NO_ARM = 3'h4;
    localparam int         PNWK_MODE_TOP    = 2;

    // Averaged bit period, 8 integer bits over 4 fraction bits
    localparam int          PNWK_AVG_W     = 12;
    localparam logic [11:0] PNWK_AVG_RESET = 12'hA00;

    // Reset values of the four status registers
    localparam logic [7:0] PNWK_RST_WAKE_STATUS = 8'h00;
    localparam logic [7:0] PNWK_RST_ERR_COUNT   = 8'h00;
    localparam logic [7:0] PNWK_RST_PERIOD_INT  = 8'hA0;
    localparam logic [7:0] PNWK_RST_PERIOD_FRAC = 8'h00;

    // Activation state, one-hot
    typedef enum logic [2:0] {
        PNWK_ST_IDLE  = 3'b001,
        PNWK_ST_ARMED = 3'b010,
        PNWK_ST_FAULT = 3'b100
    } pnwk_state_t;

endpackage : pnwk_pkg

`default_nettype wire

/* File: pnwk_status_ch2.sv */
// Partial-network wake status and supervision for CAN channel 2.
// Assumes frame decoder events, mode and config inputs come from logic on clk.
// Summary of operation
// R1 - Sync flag sets after an error-free frame, clears when wake function inactive.
// R2 - Bus-quiet flag reflects silence timeout only during partial-network wake.
// R3 - Active flag needs no channel fault, valid config, mode top bit set.
// R4 - A channel mode change arms wake, except when the new mode is 100.
// R5 - Wake pattern bit sets when a pattern is detected, holds until reset.
// R6 - Wake frame bit sets when a conforming wake frame is detected while wake is active.
// R7 - Unused status bits read as zero.
// R8 - Six-bit frame error count; zero means none, 31 means 31 errors.
// R9 - Valid frame decrements a count of 1 to 31; zero stays zero.
// R10 - Count 32 disables wake, sets channel fault, enables plain wake.
// R11 - Integer part of averaged bit period appears in high recovery register.
// R12 - Fraction nibble of averaged bit period appears in low recovery bits 7:4.
// R13 - Reset loads A0 into high recovery register, zero into the others.
// R14 - Each bad frame while active increments the count, saturating at overflow.
// R15 - Status registers are read-only; all state updates on clk.
`timescale 1ns/100ps
`default_nettype none

module pnwk_status_ch2
    import pnwk_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  frame_ok,
    input  wire logic                  frame_err,
    input  wire logic                  silence_exceeded,
    input  wire logic                  wake_pattern_det,
    input  wire logic                  wake_frame_det,
    input  wire logic                  avg_valid,
    input  wire logic [PNWK_AVG_W-1:0] averaged_bit_period,
    input  wire logic                  config_valid_flag,
    input  wire logic [2:0]            channel_mode_field,
    input  wire logic                  rd_en,
    input  wire logic                  wr_en,
    input  wire logic [6:0]            rd_addr,
    input  wire logic [7:0]            wr_data,
    output var  logic [7:0]            rd_data,
    output var  logic                  rd_valid,
    output var  logic                  partial_net_active_flag,
    output var  logic                  channel_fault_flag,
    output var  logic                  wake_capable_en
);

    pnwk_state_t           state_r;
    pnwk_state_t           state_nxt;
    logic [2:0]            mode_r;
    logic [2:0]            mode_nxt;
    logic                  active_r;
    logic                  active_nxt;
    logic                  sync_r;
    logic                  sync_nxt;
    logic                  quiet_r;
    logic                  quiet_nxt;
    logic                  wup_r;
    logic                  wup_nxt;
    logic                  wuf_r;
    logic                  wuf_nxt;
    logic [PNWK_AVG_W-1:0] bit_period_average_r;
    logic [PNWK_AVG_W-1:0] bit_period_average_nxt;
    logic [7:0]            rd_data_r;
    logic [7:0]            rd_data_nxt;
    logic                  rd_valid_r;
    logic                  wake_cap_r;
    logic                  fault_nxt;
    logic                  mode_change;
    logic [PNWK_CNT_W-1:0] bad_frame_count;
    logic                  cnt_overflow;
    logic                  wr_ignored;

    // Writes land on read-only registers and are dropped
    assign wr_ignored = wr_en & (|wr_data); // R15

    // Register image decode, shared by the read path and the checks;
    // all state comes in as arguments so a check sees sampled values
    function automatic logic [7:0] reg_image(
        input logic [6:0]            addr,
        input logic                  sync,
        input logic                  quiet,
        input logic                  active,
        input logic                  wup,
        input logic                  wuf,
        input logic [PNWK_CNT_W-1:0] cnt,
        input logic [PNWK_AVG_W-1:0] avg
    );
        logic [7:0] img;
        img = 8'h00;
        unique case (addr)
            PNWK_ADDR_WAKE_STATUS: begin
                img[PNWK_BIT_SYNC]   = sync;
                img[PNWK_BIT_QUIET]  = quiet;
                img[PNWK_BIT_ACTIVE] = active;
                img[PNWK_BIT_WUP]    = wup;
                img[PNWK_BIT_WUF]    = wuf;
            end
            PNWK_ADDR_ERR_COUNT:   img = {2'h0, cnt};
            PNWK_ADDR_PERIOD_INT:  img = avg[11:4]; // R11
            PNWK_ADDR_PERIOD_FRAC: img = {avg[3:0], 4'h0}; // R12
            default:               img = 8'h00;
        endcase
        return img; // R7
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Frame error counter; errors only count while wake is active
    pnwk_err_counter u_err_counter (
        .clk             (clk),
        .rst_n           (rst_n),
        .count_up        (frame_err & active_r), // R14
        .count_down      (frame_ok), // R9
        .bad_frame_count (bad_frame_count),
        .overflow        (cnt_overflow)
    );

    ////////////////////////////////////////////////////////////////////////
    // Activation state; fault is sticky until reset so the plain wake path
    // stays armed for the next pattern
    assign mode_change = (channel_mode_field != mode_r);

    always_comb begin
        state_nxt = state_r;
        mode_nxt  = channel_mode_field;
        unique case (state_r)
            PNWK_ST_IDLE: begin
                if (cnt_overflow) begin
                    state_nxt = PNWK_ST_FAULT; // R10
                end else if (mode_change && channel_mode_field != PNWK_MODE_NO_ARM) begin
                    state_nxt = PNWK_ST_ARMED; // R4
                end
            end
            PNWK_ST_ARMED: begin
                if (cnt_overflow) begin
                    state_nxt = PNWK_ST_FAULT; // R10
                end else if (mode_change && channel_mode_field == PNWK_MODE_NO_ARM) begin
                    state_nxt = PNWK_ST_IDLE; // R4
                end
            end
            PNWK_ST_FAULT: begin
                state_nxt = PNWK_ST_FAULT;
            end
            default: begin
                state_nxt = PNWK_ST_IDLE;
            end
        endcase
        fault_nxt  = (state_nxt == PNWK_ST_FAULT);
        active_nxt = (state_nxt == PNWK_ST_ARMED) && !fault_nxt && config_valid_flag
                     && channel_mode_field[PNWK_MODE_TOP]; // R3
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= PNWK_ST_IDLE;
            mode_r     <= PNWK_MODE_NO_ARM;
            active_r   <= 1'b0;
            wake_cap_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            mode_r     <= mode_nxt;
            active_r   <= active_nxt;
            wake_cap_r <= fault_nxt; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; detections are sticky, sync and quiet follow activity
    always_comb begin
        sync_nxt  = active_r && (sync_r || (frame_ok && !frame_err)); // R1
        quiet_nxt = active_r && silence_exceeded; // R2
        wup_nxt   = wup_r || wake_pattern_det; // R5
        wuf_nxt   = wuf_r || (wake_frame_det && active_r); // R6
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_r  <= PNWK_RST_WAKE_STATUS[PNWK_BIT_SYNC]; // R13
            quiet_r <= PNWK_RST_WAKE_STATUS[PNWK_BIT_QUIET];
            wup_r   <= PNWK_RST_WAKE_STATUS[PNWK_BIT_WUP];
            wuf_r   <= PNWK_RST_WAKE_STATUS[PNWK_BIT_WUF];
        end else begin
            sync_r  <= sync_nxt;
            quiet_r <= quiet_nxt;
            wup_r   <= wup_nxt;
            wuf_r   <= wuf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Averaged bit period from the clock recovery filter
    always_comb begin
        bit_period_average_nxt = avg_valid ? averaged_bit_period : bit_period_average_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_period_average_r <= PNWK_AVG_RESET; // R13
        end else begin
            bit_period_average_r <= bit_period_average_nxt; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; one cycle latency, unmapped addresses return zero
    always_comb begin
        rd_data_nxt = rd_en ? reg_image(rd_addr, sync_r, quiet_r, active_r, wup_r, wuf_r,
                                        bad_frame_count, bit_period_average_r) : rd_data_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_en;
        end
    end

    assign rd_data                 = rd_data_r;
    assign rd_valid                = rd_valid_r;
    assign partial_net_active_flag = active_r;
    assign channel_fault_flag      = wake_cap_r;
    assign wake_capable_en         = wake_cap_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_overflow_hit;
        cnt_overflow;
    endsequence

    sequence s_fault_held;
        wake_cap_r && !active_r;
    endsequence

    AST_OVF_DISABLES: assert property (@(posedge clk) disable iff (!rst_n) // R10
        s_overflow_hit |=> s_fault_held ##1 s_fault_held)
        else $error("overflow did not disable wake and raise fault");

    AST_SYNC_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // R1
        $rose(sync_r) |-> $past(frame_ok) && $past(active_r))
        else $error("sync flag rose without a good frame");

    AST_SYNC_DROP: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !active_r |=> !sync_r)
        else $error("sync flag held while wake inactive");

    AST_QUIET_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n) // R2
        quiet_r == $past(active_r && silence_exceeded))
        else $error("bus quiet flag wrong");

    AST_ACTIVE_COND: assert property (@(posedge clk) disable iff (!rst_n) // R3
        active_r |-> !wake_cap_r && $past(config_valid_flag)
                     && $past(channel_mode_field[PNWK_MODE_TOP]))
        else $error("active flag set without its conditions");

    AST_NO_ARM_100: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (state_r == PNWK_ST_IDLE && channel_mode_field == PNWK_MODE_NO_ARM)
            |=> state_r != PNWK_ST_ARMED)
        else $error("mode 100 armed partial-network wake");

    AST_WUP_SET: assert property (@(posedge clk) disable iff (!rst_n) // R5
        wake_pattern_det |=> wup_r)
        else $error("wake pattern not flagged");

    AST_WUF_SET: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (wake_frame_det && active_r) |=> wuf_r)
        else $error("wake frame not flagged");

    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // R7
        rd_valid_r |-> rd_data_r == $past(reg_image(rd_addr, sync_r, quiet_r, active_r, wup_r, wuf_r,
                                                    bad_frame_count, bit_period_average_r))
                       && !(($past(rd_addr) == PNWK_ADDR_WAKE_STATUS) && (|rd_data_r[5:4] || rd_data_r[7]))
                       && !(($past(rd_addr) == PNWK_ADDR_PERIOD_FRAC) && (|rd_data_r[3:0])))
        else $error("read data or reserved bits wrong");

    AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // R15
        (wr_ignored && !avg_valid) |=> $stable(bit_period_average_r))
        else $error("write changed a read-only register");

    AST_PERIOD_LOAD: assert property (@(posedge clk) disable iff (!rst_n) // R12
        avg_valid |=> bit_period_average_r == $past(averaged_bit_period))
        else $error("averaged bit period not captured");

    AST_ARM_ON_CHANGE: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (state_r == PNWK_ST_IDLE && !cnt_overflow && mode_change && channel_mode_field != PNWK_MODE_NO_ARM)
            |=> state_r == PNWK_ST_ARMED)
        else $error("mode change did not arm partial-network wake");

    AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // R10
        wake_cap_r |=> wake_cap_r && state_r == PNWK_ST_FAULT)
        else $error("channel fault cleared without reset");

    AST_WUP_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // R5
        $rose(wup_r) |-> $past(wake_pattern_det))
        else $error("wake pattern flag rose without a pattern");

    AST_WUP_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // R5
        wup_r |=> wup_r)
        else $error("wake pattern flag cleared without reset");

    AST_WUF_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // R6
        $rose(wuf_r) |-> $past(wake_frame_det) && $past(active_r))
        else $error("wake frame flag rose without an active wake frame");

    AST_PERIOD_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R11
        !avg_valid |=> $stable(bit_period_average_r))
        else $error("averaged bit period moved without a valid strobe");

endmodule // pnwk_status_ch2

`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the channel 2 partial-network wake status block.
// Assumes the block's own assertions sit in its files; the bus node model drives events.
`timescale 1ns/100ps
`default_nettype none

module tb
    import pnwk_pkg::*;
;
    logic                  clk;
    logic                  rst_n;
    logic                  frame_ok;
    logic                  frame_err;
    logic                  silence_exceeded;
    logic                  wake_pattern_det;
    logic                  wake_frame_det;
    logic                  avg_valid;
    logic [PNWK_AVG_W-1:0] averaged_bit_period;
    logic                  cfg;
    logic [2:0]            mode;
    logic                  rd_en;
    logic                  wr_en;
    logic [6:0]            rd_addr;
    logic [7:0]            wr_data;
    logic [7:0]            rd_data;
    logic                  rd_valid;
    logic                  active;
    logic                  fault;
    logic                  wce;
    int                    bad_count = 0;
    int                    cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and bus node
    pnwk_status_ch2 i_dut (.clk(clk), .rst_n(rst_n), .frame_ok(frame_ok), .frame_err(frame_err),
        .silence_exceeded(silence_exceeded), .wake_pattern_det(wake_pattern_det),
        .wake_frame_det(wake_frame_det), .avg_valid(avg_valid), .averaged_bit_period(averaged_bit_period),
        .config_valid_flag(cfg), .channel_mode_field(mode), .rd_en(rd_en), .wr_en(wr_en),
        .rd_addr(rd_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .partial_net_active_flag(active), .channel_fault_flag(fault), .wake_capable_en(wce));
    pnwk_can_node i_node (.clk(clk), .frame_ok(frame_ok), .frame_err(frame_err),
        .silence_exceeded(silence_exceeded), .wake_pattern_det(wake_pattern_det),
        .wake_frame_det(wake_frame_det), .avg_valid(avg_valid), .averaged_bit_period(averaged_bit_period));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared checks and register access
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strobe read; answer lands on the taking edge and is checked just after it
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({rd_valid, rd_data}, {1'b1, exp});
    endtask

    // Compares active, fault and wake-capable after the state has settled
    task automatic flags(input logic [2:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk({6'h00, active, fault, wce}, {6'h00, exp});
    endtask

    task automatic mode_to(input logic [2:0] m, input logic c, input logic [2:0] exp);
        @(posedge clk);
        mode <= m;
        cfg  <= c;
        flags(exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_vals();
        rd(PNWK_ADDR_WAKE_STATUS, 8'h00);
        rd(PNWK_ADDR_ERR_COUNT, 8'h00);
        rd(PNWK_ADDR_PERIOD_INT, 8'hA0);
        rd(PNWK_ADDR_PERIOD_FRAC, 8'h00);
        flags(3'h0);
    endtask

    // Wake frame while idle must be ignored; then walk through the arming conditions
    task automatic t_arming();
        i_node.burst(3, 1);
        rd(PNWK_ADDR_WAKE_STATUS, 8'h00);
        mode_to(3'h0, 1'b1, 3'h0);
        mode_to(3'h6, 1'b0, 3'h0);
        mode_to(3'h6, 1'b1, 3'h4);
        mode_to(3'h4, 1'b1, 3'h0);
        i_node.burst(1, 2);
        rd(PNWK_ADDR_ERR_COUNT, 8'h00);
        mode_to(3'h5, 1'b1, 3'h4);
    endtask

    task automatic t_status();
        i_node.burst(1, 3);
        rd(PNWK_ADDR_ERR_COUNT, 8'h03);
        i_node.burst(0, 1);
        rd(PNWK_ADDR_ERR_COUNT, 8'h02);
        i_node.burst(0, 3);
        rd(PNWK_ADDR_ERR_COUNT, 8'h00);
        i_node.quiet(1'b1);
        i_node.burst(2, 1);
        i_node.burst(3, 1);
        rd(PNWK_ADDR_WAKE_STATUS, 8'h4F);
        i_node.quiet(1'b0);
        rd(PNWK_ADDR_WAKE_STATUS, 8'h47);
    endtask

    // Climb to overflow; fault is sticky and the count freezes
    task automatic t_counter();
        i_node.burst(1, 31);
        rd(PNWK_ADDR_ERR_COUNT, 8'h1F);
        i_node.burst(1, 1);
        flags(3'h3);
        rd(PNWK_ADDR_ERR_COUNT, 8'h20);
        rd(PNWK_ADDR_WAKE_STATUS, 8'h03);
        i_node.burst(1, 2);
        i_node.burst(0, 1);
        rd(PNWK_ADDR_ERR_COUNT, 8'h20);
    endtask

    task automatic t_period();
        i_node.period(12'h5B7);
        rd(PNWK_ADDR_PERIOD_INT, 8'h5B);
        rd(PNWK_ADDR_PERIOD_FRAC, 8'h70);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_data <= 8'hFF;
        rd_addr <= PNWK_ADDR_PERIOD_INT;
        @(posedge clk);
        wr_en <= 1'b0;
        rd(PNWK_ADDR_PERIOD_INT, 8'h5B);
        rd(7'h10, 8'h00);
    endtask

    // Mode parked at 100 first: a non-100 mode at release counts as a change and arms
    task automatic t_mid_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        mode  <= 3'h4;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
    endtask

    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, main sequence and watchdog; runs are about 150 cycles
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst_n   = 1'b0;
        cfg     = 1'b0;
        mode    = 3'h4;
        rd_en   = 1'b0;
        wr_en   = 1'b0;
        rd_addr = 7'h00;
        wr_data = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_arming();
        t_status();
        t_counter();
        t_period();
        t_mid_reset();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule // tb

`default_nettype wire
